/* hw/bptx_map.vh */
// constants, register map and link encodings of the backplane transmit port
`ifndef BPTX_MAP_VH
`define BPTX_MAP_VH

// serial word geometry
`define BPTX_DATA_BITS      32
`define BPTX_KIND_BITS      2
`define BPTX_WORD_BITS      34
`define BPTX_CELL_WORDS     16

// word kinds carried in the overhead bits
`define BPTX_KIND_IDLE      2'h0
`define BPTX_KIND_DATA      2'h1
`define BPTX_KIND_START     2'h2
`define BPTX_KIND_END       2'h3

// idle word body; low three bits carry link control
`define BPTX_IDLE_WORD      32'hBC5A_0F30
`define BPTX_IDLE_HI        31
`define BPTX_IDLE_LO        3
`define BPTX_IDLE_BP        0
`define BPTX_IDLE_ACK       1
`define BPTX_IDLE_NAK       2

// register byte addresses
`define BPTX_ADDR_W         4
`define BPTX_REG_CTRL       4'h0
`define BPTX_REG_STATUS     4'h4
`define BPTX_REG_MASK       4'h8
`define BPTX_REG_STATE      4'hC

// control fields
`define BPTX_CTRL_BYPASS    0
`define BPTX_CTRL_CELL      1
`define BPTX_CTRL_MODE1     2
`define BPTX_CTRL_RESET     3'h0

// status and mask fields
`define BPTX_EV_W           4
`define BPTX_EV_CELLERR     0
`define BPTX_EV_REREAD      1
`define BPTX_EV_DELIVERED   2
`define BPTX_EV_ALIGNED     3
`define BPTX_EV_RESET       4'h0

`endif

/* hw/bptx_serializer.v */
// shifts a 34-bit link word out msb first, one bit per clock
`timescale 1ns/1ps
`include "bptx_map.vh"
module bptx_serializer #(
	parameter WORD_BITS = `BPTX_WORD_BITS
)(
	input  wire                 clk_sys,
	input  wire                 rstn,
	input  wire                 load,
	input  wire [WORD_BITS-1:0] word,
	output reg                  serialOut
);

reg [WORD_BITS-1:0] shiftReg;

always @(posedge clk_sys or negedge rstn)
begin
	if (!rstn)
	begin
		shiftReg  <= {WORD_BITS{1'b0}};
		serialOut <= 1'b0;
	end
	else if (load)
	begin
		shiftReg  <= {word[WORD_BITS-2:0], 1'b0};
		serialOut <= word[WORD_BITS-1];
	end
	else
	begin
		shiftReg  <= {shiftReg[WORD_BITS-2:0], 1'b0};
		serialOut <= shiftReg[WORD_BITS-1];
	end
end

endmodule // bptx_serializer

/* hw/bptx_parallel_if.v */
// transmit parallel port, link framing and receive deframing
// Functional notes
// - each accepted 32-bit word goes out as one 34-bit serial word
// - each received 34-bit serial word becomes a 32-bit word plus kind
// - without bypass the two kind inputs give the word type
// - load-enable high captures data and kind at the next word tick; the code captures only while read-enable is high
// - load-enable low ignores inputs and sends idle words
// - downstream-ready low sends back-pressure in idle words
// - cell mode with downstream-ready high recovers cells from the stream
// - packet mode without bypass raises retransmit-pending at packet start
// - retransmit-pending falls when delivery is acknowledged
// - without bypass reread-from-marker rises on a retransmit request
// - alignment flag low while mode bit 1 high and link aligned
// - after alignment the flag pulses high one word on cell clock error
// - read-enable high while ready to take words from the inputs
// - received back-pressure forces read-enable low
//
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "bptx_map.vh"
module bptx_parallel_if #(
	parameter WORD_BITS  = `BPTX_WORD_BITS,
	parameter CELL_WORDS = `BPTX_CELL_WORDS
)(
	input  wire                         clk_sys,
	input  wire                         resetn,
	input  wire [`BPTX_DATA_BITS-1:0]   tx_word_in,
	input  wire [`BPTX_KIND_BITS-1:0]   tx_word_kind,
	input  wire                         tx_load_enable,
	input  wire                         downstream_ready,
	input  wire                         cellClockIn,
	input  wire                         rxSerialIn,
	input  wire [`BPTX_ADDR_W-1:0]      regAddr,
	input  wire [31:0]                  regWrData,
	input  wire                         regWrite,
	input  wire                         regRead,
	output reg  [31:0]                  regRdData,
	output reg                          irq,
	output wire                         txSerialOut,
	output reg                          fifoReadEnable,
	output reg                          retx_pending_or_cell_tick,
	output reg                          reread_from_marker,
	output reg                          tx_alignment_flag,
	output reg  [`BPTX_DATA_BITS-1:0]   rxWordOut,
	output reg  [`BPTX_KIND_BITS-1:0]   rxWordKind,
	output reg                          rxWordValid
);

localparam CNT_W = 6;
localparam CELL_W = 8;
localparam [`BPTX_DATA_BITS-1:0] IDLE_WORD = `BPTX_IDLE_WORD;
localparam [CNT_W-1:0]           ERR_LEN   = WORD_BITS;

function [CNT_W-1:0] incWrap;
	input [CNT_W-1:0] value;
	begin
		incWrap = (value == WORD_BITS - 1) ? {CNT_W{1'b0}} : value + 1'b1;
	end
endfunction

// reset release and pin synchronisers
reg [1:0]  rstPipe;
reg [1:0]  loadSync;
reg [1:0]  readySync;
reg [1:0]  cellSync;
reg [1:0]  rxSync;
reg [31:0] dataMeta;
reg [31:0] dataSync;
reg [1:0]  kindMeta;
reg [1:0]  kindSync;
reg        cellPrev;
wire       rstn = rstPipe[1];

always @(posedge clk_sys or negedge resetn)
begin
	if (!resetn)
		rstPipe <= 2'h0;
	else
		rstPipe <= {rstPipe[0], 1'b1};
end

always @(posedge clk_sys or negedge rstn)
begin
	if (!rstn)
	begin
		loadSync  <= 2'h0;
		readySync <= 2'h0;
		cellSync  <= 2'h0;
		rxSync    <= 2'h0;
		dataMeta  <= 32'h0000_0000;
		dataSync  <= 32'h0000_0000;
		kindMeta  <= 2'h0;
		kindSync  <= 2'h0;
		cellPrev  <= 1'b0;
	end
	else
	begin
		loadSync  <= {loadSync[0], tx_load_enable};
		readySync <= {readySync[0], downstream_ready};
		cellSync  <= {cellSync[0], cellClockIn};
		rxSync    <= {rxSync[0], rxSerialIn};
		dataMeta  <= tx_word_in;
		dataSync  <= dataMeta;
		kindMeta  <= tx_word_kind;
		kindSync  <= kindMeta;
		cellPrev  <= cellSync[1];
	end
end

// registers
reg  [2:0]             ctrl;
reg  [`BPTX_EV_W-1:0]  status;
reg  [`BPTX_EV_W-1:0]  mask;
wire                   bypass   = ctrl[`BPTX_CTRL_BYPASS];
wire                   cellMode = ctrl[`BPTX_CTRL_CELL];
wire                   modeBit1 = ctrl[`BPTX_CTRL_MODE1];

// word clock enable
reg  [CNT_W-1:0] bitCount;
wire             wordTick = (bitCount == WORD_BITS - 1);

always @(posedge clk_sys or negedge rstn)
begin
	if (!rstn)
		bitCount <= {CNT_W{1'b0}};
	else
		bitCount <= incWrap(bitCount);
end

// receive deframer
reg  [WORD_BITS-1:0] rxShift;
reg  [CNT_W-1:0]     rxCount;
reg                  rxAligned;
reg                  rxBackPressure;
wire [1:0]           rxKindNow = rxShift[WORD_BITS-1:WORD_BITS-2];
wire                 idleMatch = (rxKindNow == `BPTX_KIND_IDLE) &&
	(rxShift[`BPTX_IDLE_HI:`BPTX_IDLE_LO] ==
	 IDLE_WORD[`BPTX_IDLE_HI:`BPTX_IDLE_LO]);
wire                 wordDone = rxAligned && (rxCount == WORD_BITS - 1);
wire                 rxIdle   = wordDone && idleMatch;
wire                 rxAck    = rxIdle && rxShift[`BPTX_IDLE_ACK];
wire                 rxNak    = rxIdle && rxShift[`BPTX_IDLE_NAK];
wire                 rxStart  = wordDone && (rxKindNow == `BPTX_KIND_START);
wire                 gainAlign = !rxAligned && idleMatch;

always @(posedge clk_sys or negedge rstn)
begin
	if (!rstn)
	begin
		rxShift        <= {WORD_BITS{1'b0}};
		rxCount        <= {CNT_W{1'b0}};
		rxAligned      <= 1'b0;
		rxBackPressure <= 1'b0;
		rxWordOut      <= 32'h0000_0000;
		rxWordKind     <= 2'h0;
		rxWordValid    <= 1'b0;
	end
	else
	begin
		rxShift     <= {rxShift[WORD_BITS-2:0], rxSync[1]};
		rxWordValid <= 1'b0;
		if (gainAlign)
		begin
			rxAligned <= 1'b1;
			rxCount   <= {CNT_W{1'b0}};
		end
		else if (rxAligned)
			rxCount <= incWrap(rxCount);
		if (wordDone)
		begin
			rxWordOut   <= rxShift[`BPTX_DATA_BITS-1:0];
			rxWordKind  <= rxKindNow;
			rxWordValid <= bypass || !idleMatch;
			if (rxKindNow == `BPTX_KIND_IDLE && !idleMatch && !bypass)
				rxAligned <= 1'b0;
			if (idleMatch)
				rxBackPressure <= rxShift[`BPTX_IDLE_BP];
		end
	end
end

// transmit word build
wire        loadNow = wordTick && loadSync[1] && fifoReadEnable;
wire [31:0] idleBody = {IDLE_WORD[`BPTX_IDLE_HI:`BPTX_IDLE_BP+1],
	!readySync[1]};
wire [WORD_BITS-1:0] txWord = loadNow ?
	{kindSync, dataSync} :
	{`BPTX_KIND_IDLE, idleBody};

bptx_serializer #(
	.WORD_BITS (WORD_BITS)
) u_serializer (
	.clk_sys   (clk_sys),
	.rstn      (rstn),
	.load      (wordTick),
	.word      (txWord),
	.serialOut (txSerialOut)
);

// cell timing
reg  [CELL_W-1:0] cellCount;
reg               cellTickPulse;
reg  [CNT_W-1:0]  errLeft;
wire              extEdge = cellSync[1] && !cellPrev;
wire              resync = cellMode &&
	(readySync[1] ? rxStart : extEdge);
wire              cellErr = resync && rxAligned &&
	(cellCount != {CELL_W{1'b0}});

always @(posedge clk_sys or negedge rstn)
begin
	if (!rstn)
	begin
		cellCount     <= {CELL_W{1'b0}};
		cellTickPulse <= 1'b0;
		errLeft       <= {CNT_W{1'b0}};
	end
	else
	begin
		cellTickPulse <= 1'b0;
		if (resync)
			cellCount <= {CELL_W{1'b0}};
		else if (wordTick)
		begin
			cellTickPulse <= (cellCount == {CELL_W{1'b0}});
			if (cellCount == CELL_WORDS - 1)
				cellCount <= {CELL_W{1'b0}};
			else
				cellCount <= cellCount + 1'b1;
		end
		if (cellErr)
			errLeft <= ERR_LEN;
		else if (errLeft != {CNT_W{1'b0}})
			errLeft <= errLeft - 1'b1;
	end
end

// port card handshake outputs
reg retxPending;

always @(posedge clk_sys or negedge rstn)
begin
	if (!rstn)
	begin
		retxPending               <= 1'b0;
		fifoReadEnable            <= 1'b0;
		retx_pending_or_cell_tick <= 1'b0;
		reread_from_marker        <= 1'b0;
		tx_alignment_flag         <= 1'b1;
	end
	else
	begin
		if (loadNow && !bypass && !cellMode &&
			kindSync == `BPTX_KIND_START)
			retxPending <= 1'b1;
		else if (rxAck)
			retxPending <= 1'b0;
		fifoReadEnable <= !rxBackPressure;
		retx_pending_or_cell_tick <= cellMode ?
			cellTickPulse : retxPending;
		reread_from_marker <= rxNak && !bypass;
		tx_alignment_flag <= (errLeft != {CNT_W{1'b0}}) ||
			!(modeBit1 && rxAligned);
	end
end

// register file and interrupt
wire [`BPTX_EV_W-1:0] events;
wire [`BPTX_EV_W-1:0] clearBits;
wire [`BPTX_EV_W-1:0] nextStatus;

assign events[`BPTX_EV_CELLERR]   = cellErr;
assign events[`BPTX_EV_REREAD]    = rxNak && !bypass;
assign events[`BPTX_EV_DELIVERED] = rxAck && retxPending;
assign events[`BPTX_EV_ALIGNED]   = gainAlign;
assign clearBits = (regWrite && regAddr == `BPTX_REG_STATUS) ?
	regWrData[`BPTX_EV_W-1:0] : {`BPTX_EV_W{1'b0}};
assign nextStatus = (status & ~clearBits) | events;

always @(posedge clk_sys or negedge rstn)
begin
	if (!rstn)
	begin
		ctrl      <= `BPTX_CTRL_RESET;
		status    <= `BPTX_EV_RESET;
		mask      <= `BPTX_EV_RESET;
		regRdData <= 32'h0000_0000;
		irq       <= 1'b0;
	end
	else
	begin
		status <= nextStatus;
		irq    <= |(nextStatus & mask);
		if (regWrite && regAddr == `BPTX_REG_CTRL)
			ctrl <= regWrData[2:0];
		if (regWrite && regAddr == `BPTX_REG_MASK)
			mask <= regWrData[`BPTX_EV_W-1:0];
		regRdData <= 32'h0000_0000;
		if (regRead)
		begin
			case (regAddr)
			`BPTX_REG_CTRL:
				regRdData <= {29'h0, ctrl};
			`BPTX_REG_STATUS:
				regRdData <= {28'h0, status};
			`BPTX_REG_MASK:
				regRdData <= {28'h0, mask};
			`BPTX_REG_STATE:
				regRdData <= {28'h0, rxBackPressure, retxPending,
					fifoReadEnable, rxAligned};
			default:
				regRdData <= 32'h0000_0000;
			endcase
		end
	end
end

endmodule // bptx_parallel_if

/* testbench/bptx_parallel_if_sva.sv */
// checker for the backplane transmit port outputs
`timescale 1ns/1ps
`include "bptx_map.vh"
module bptx_parallel_if_sva (
	input wire        clk_sys,
	input wire        resetn,
	input wire [3:0]  regAddr,
	input wire        regRead,
	input wire        regWrite,
	input wire [31:0] regRdData,
	input wire        irq,
	input wire        fifoReadEnable,
	input wire        reread_from_marker,
	input wire        tx_alignment_flag,
	input wire        rxWordValid
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	property p_rd_idle; !$past(regRead) |-> regRdData == 32'h0000_0000;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
	property p_rd_hole; $past(regRead) && ($past(regAddr) & 4'h3) != 4'h0
		|-> regRdData == 32'h0000_0000; endproperty
	a_rd_hole: assert property (p_rd_hole) else $error("unmapped read");
	property p_rd_state; $past(regRead) && $past(regAddr) == `BPTX_REG_STATE
		|-> regRdData[31:4] == 28'h000_0000; endproperty
	a_rd_state: assert property (p_rd_state) else $error("state high bits");
	property p_irq_fall; $fell(irq) |-> $past(regWrite) || $past(regWrite, 2);
	endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("irq fell alone");
	property p_rfm; reread_from_marker |=> !reread_from_marker [*8];
	endproperty
	a_rfm: assert property (p_rfm) else $error("reread pulse");
	property p_rxv; rxWordValid |=> !rxWordValid [*8]; endproperty
	a_rxv: assert property (p_rxv) else $error("rx valid spacing");
	property p_tx_alignment_flag; $rose(tx_alignment_flag) |-> tx_alignment_flag [*8];
	endproperty
	a_tx_alignment_flag: assert property (p_tx_alignment_flag) else $error("flag pulse short");
	property p_fifo; $changed(fifoReadEnable) |=> $stable(fifoReadEnable) [*8];
	endproperty
	a_fifo: assert property (p_fifo) else $error("read enable glitch");
endmodule // bptx_parallel_if_sva

/* testbench/bptx_link_peer.sv */
// link peer model: sends words and idles, collects the transmit stream
`timescale 1ns/1ps
`include "bptx_map.vh"
module bptx_link_peer (
	input  wire clk_sys,
	input  wire txSerialOut,
	output reg  rxSerialIn
);
	reg [33:0] cur = {2'h0, `BPTX_IDLE_WORD};
	reg [33:0] txShift = 34'h0_0000_0000;
	reg [5:0]  bitCount = 6'h00;
	reg [2:0]  ctl = 3'h0;
	reg [33:0] pending [$];
	initial rxSerialIn = 1'b0;
	task sendWord(input [33:0] w);
		pending.push_back(w);
	endtask
	always @(posedge clk_sys)
	begin
		txShift <= {txShift[32:0], txSerialOut};
		rxSerialIn <= cur[33];
		cur <= {cur[32:0], 1'b0};
		bitCount <= bitCount + 6'h01;
		if (bitCount == 6'h21)
		begin
			bitCount <= 6'h00;
			if (pending.size() != 0)
				cur <= pending.pop_front();
			else
			begin
				cur <= {2'h0, `BPTX_IDLE_WORD} | ctl;
				ctl[2:1] <= 2'h0;
			end
		end
	end
endmodule // bptx_link_peer

/* testbench/bptx_parallel_if_test.sv */
// self-checking bench for the backplane transmit port
`timescale 1ns/1ps
`include "bptx_map.vh"
module bptx_parallel_if_test;
	reg         clk_sys = 1'b0;
	reg         resetn = 1'b0;
	reg  [31:0] tx_word_in = 32'h0000_0000;
	reg  [1:0]  tx_word_kind = 2'h0;
	reg         tx_load_enable = 1'b0;
	reg         downstream_ready = 1'b1;
	reg         cellClockIn = 1'b0;
	reg  [3:0]  regAddr = 4'h0;
	reg  [31:0] regWrData = 32'h0000_0000;
	reg         regWrite = 1'b0;
	reg         regRead = 1'b0;
	wire [31:0] regRdData;
	wire [31:0] rxWordOut;
	wire [1:0]  rxWordKind;
	wire        irq, txSerialOut, rxSerialIn, fifoReadEnable, rxWordValid;
	wire        retx_pending_or_cell_tick, reread_from_marker;
	wire        tx_alignment_flag;
	reg  [34:0] rows [0:3];
	reg  [31:0] d;
	integer     mismatches = 0;
	integer     samples_checked = 0;
	integer     cycles = 0;
	integer     i, r, seen;
	always #2.5 clk_sys = ~clk_sys;
	bptx_parallel_if u_dut (
		.clk_sys(clk_sys), .resetn(resetn), .tx_word_in(tx_word_in),
		.tx_word_kind(tx_word_kind), .tx_load_enable(tx_load_enable),
		.downstream_ready(downstream_ready), .cellClockIn(cellClockIn),
		.rxSerialIn(rxSerialIn), .regAddr(regAddr), .regWrData(regWrData),
		.regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
		.irq(irq), .txSerialOut(txSerialOut),
		.fifoReadEnable(fifoReadEnable),
		.retx_pending_or_cell_tick(retx_pending_or_cell_tick),
		.reread_from_marker(reread_from_marker),
		.tx_alignment_flag(tx_alignment_flag), .rxWordOut(rxWordOut),
		.rxWordKind(rxWordKind), .rxWordValid(rxWordValid)
	);
	bptx_link_peer u_peer (
		.clk_sys(clk_sys), .txSerialOut(txSerialOut), .rxSerialIn(rxSerialIn)
	);
	task conclude;
	begin
		if (mismatches == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	end
	endtask
	task cmp(input [33:0] got, input [33:0] exp);
	begin
		samples_checked = samples_checked + 1;
		if (got !== exp)
		begin
			mismatches = mismatches + 1;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	end
	endtask
	task wr(input [3:0] a, input [31:0] v);
	begin
		@(posedge clk_sys);
		regWrite <= 1'b1;
		regAddr <= a;
		regWrData <= v;
		@(posedge clk_sys);
		regWrite <= 1'b0;
	end
	endtask
	task rd(input [3:0] a, output [31:0] q);
	begin
		@(posedge clk_sys);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge clk_sys);
		regRead <= 1'b0;
		@(negedge clk_sys);
		q = regRdData;
	end
	endtask
	function outSel(input integer s);
	begin
		case (s)
			0: outSel = retx_pending_or_cell_tick;
			1: outSel = reread_from_marker;
			2: outSel = fifoReadEnable;
			3: outSel = tx_alignment_flag;
			4: outSel = rxWordValid;
			default: outSel = irq;
		endcase
	end
	endfunction
	task waitOut(input integer s, input v, input integer n);
	begin
		i = 0;
		do begin @(posedge clk_sys); i = i + 1; end
		while (i < n && outSel(s) !== v);
		cmp(outSel(s), v);
	end
	endtask
	task txSeen(input [33:0] exp, input [33:0] care);
	begin
		i = 0;
		do begin @(posedge clk_sys); i = i + 1; end
		while (i < 200 && (u_peer.txShift & care) !== (exp & care));
		cmp(u_peer.txShift & care, exp & care);
	end
	endtask
	initial
	begin
		rows[0] = {1'b0, `BPTX_KIND_START, 32'h1234_5678};
		rows[1] = {1'b0, `BPTX_KIND_DATA, 32'hFFFF_0000};
		rows[2] = {1'b0, `BPTX_KIND_END, 32'h0000_0001};
		rows[3] = {1'b1, 2'h0, 32'hA5A5_5A5A};
		repeat (10) @(posedge clk_sys);
		resetn <= 1'b1;
		repeat (3) @(posedge clk_sys);
		for (r = 0; r < 4; r = r + 1)
		begin
			rd(4'(r * 4 - (r / 3) * 10), d);
			cmp(d, 34'h0_0000_0000);
		end
		for (r = 0; r < 4; r = r + 1)
		begin
			wr(`BPTX_REG_CTRL, {31'h0, rows[r][34]});
			tx_word_kind <= rows[r][33:32];
			tx_word_in <= rows[r][31:0];
			tx_load_enable <= 1'b1;
			txSeen(rows[r][33:0], 34'h3_FFFF_FFFF);
			if (r == 0)
				cmp(retx_pending_or_cell_tick, 1'b1);
		end
		tx_load_enable <= 1'b0;
		wr(`BPTX_REG_CTRL, 32'h0000_0000);
		txSeen({2'h0, `BPTX_IDLE_WORD}, 34'h3_FFFF_FFF9);
		downstream_ready <= 1'b0;
		txSeen({2'h0, `BPTX_IDLE_WORD} | 34'h1, 34'h3_FFFF_FFF9);
		downstream_ready <= 1'b1;
		@(negedge clk_sys) u_peer.ctl[1] = 1'b1;
		waitOut(0, 1'b0, 99);
		rd(`BPTX_REG_STATUS, d);
		cmp(d[2], 1'b1);
		@(negedge clk_sys) u_peer.ctl[2] = 1'b1;
		waitOut(1, 1'b1, 99);
		waitOut(5, 1'b0, 4);
		wr(`BPTX_REG_MASK, 32'h0000_0002);
		waitOut(5, 1'b1, 4);
		wr(`BPTX_REG_STATUS, 32'h0000_0002);
		waitOut(5, 1'b0, 4);
		wr(`BPTX_REG_CTRL, 32'h0000_0001);
		@(negedge clk_sys) u_peer.ctl[2] = 1'b1;
		seen = 0;
		repeat (99) @(posedge clk_sys) seen = seen | reread_from_marker;
		cmp(seen, 34'h0_0000_0000);
		wr(`BPTX_REG_CTRL, 32'h0000_0000);
		@(negedge clk_sys) u_peer.ctl[0] = 1'b1;
		waitOut(2, 1'b0, 99);
		@(negedge clk_sys) u_peer.ctl[0] = 1'b0;
		waitOut(2, 1'b1, 99);
		@(negedge clk_sys) u_peer.sendWord({`BPTX_KIND_DATA, 32'hCAFE_0042});
		waitOut(4, 1'b1, 150);
		cmp(rxWordOut, 32'hCAFE_0042);
		cmp(rxWordKind, `BPTX_KIND_DATA);
		wr(`BPTX_REG_CTRL, 32'h0000_0004);
		waitOut(3, 1'b0, 99);
		wr(`BPTX_REG_CTRL, 32'h0000_0006);
		waitOut(0, 1'b1, 600);
		waitOut(0, 1'b0, 1);
		downstream_ready <= 1'b0;
		repeat (2)
		begin
			repeat (170) @(posedge clk_sys);
			cellClockIn <= 1'b1;
			repeat (4) @(posedge clk_sys);
			cellClockIn <= 1'b0;
		end
		waitOut(3, 1'b1, 40);
		waitOut(3, 1'b0, 60);
		downstream_ready <= 1'b1;
		@(negedge clk_sys) u_peer.sendWord({`BPTX_KIND_START, 32'h0000_0000});
		waitOut(3, 1'b1, 150);
		waitOut(3, 1'b0, 60);
		resetn <= 1'b0;
		repeat (3) @(posedge clk_sys);
		cmp(tx_alignment_flag, 1'b1);
		cmp(fifoReadEnable, 1'b0);
		resetn <= 1'b1;
		repeat (3) @(posedge clk_sys);
		conclude;
	end
	always @(posedge clk_sys)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			mismatches = mismatches + 1;
			conclude;
		end
	end
endmodule // bptx_parallel_if_test
bind bptx_parallel_if bptx_parallel_if_sva u_sva (
	.clk_sys(clk_sys), .resetn(resetn), .regAddr(regAddr),
	.regRead(regRead), .regWrite(regWrite), .regRdData(regRdData),
	.irq(irq), .fifoReadEnable(fifoReadEnable),
	.reread_from_marker(reread_from_marker),
	.tx_alignment_flag(tx_alignment_flag), .rxWordValid(rxWordValid)
);
